// File: hw/spc_pkg.sv
// Purpose: constants and types shared by the stop-mode power controller
// Assumes: 10 MHz core clock, 8-bit register port
// Notes:   all offsets, field positions but the status state and mode fields, config reset values and counts live here
package spc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned WAKE_RST_NS  = 400;
  localparam int unsigned WAKE_RST_CYC =
    (WAKE_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_PWR_MODE = 3'h0;
  localparam logic [2:0] OFS_SYS_OPT  = 3'h1;
  localparam logic [2:0] OFS_DBG_CTL  = 3'h2;
  localparam logic [2:0] OFS_CLK_CFG  = 3'h3;
  localparam logic [2:0] OFS_STATUS   = 3'h4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned PM_DSS_BIT  = 0;
  localparam int unsigned PM_ACK_BIT  = 1;
  localparam int unsigned PM_FLAG_BIT = 2;
  localparam int unsigned PM_LOW_VOLT_DETECT_ENABLE_BIT = 3;
  localparam int unsigned PM_LVSE_BIT = 4;
  localparam int unsigned SO_STOP_BIT = 0;
  localparam int unsigned DC_DEE_BIT  = 0;
  localparam int unsigned CC_OSC_BIT  = 0;
  localparam int unsigned CC_ADAC_BIT = 1;
  localparam int unsigned ST_LATCH_BIT = 7;
  // ----------------------------------------------------------------
  // reset values and wake sources
  // ----------------------------------------------------------------
  localparam logic       CFG_RST_VAL    = 1'b0;
  localparam int unsigned N_WAKE        = 6;
  localparam logic [5:0] DEEP_WAKE_MASK = 6'h09;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPC_MODE_LIGHT, SPC_MODE_DEEP} spc_mode_e;
  typedef enum logic [2:0] {ST_RUN, ST_LIGHT, ST_DEEP, ST_WAKE, ST_BGND} spc_state_e;
endpackage

// File: hw/spc_stop_if.sv
// Purpose: carries stop configuration to the mode resolver and its answer back
// Assumes: purely combinational exchange within one clock domain
// Notes:   req side owns the configuration, res side owns the decision
`timescale 1ns/1ps
`default_nettype none
interface spc_stop_if;
  import spc_pkg::*;
  logic      deep_sel;   // deep-stop select bit
  logic      dbg_en;     // debug entry enable
  logic      lvd_stop;   // detector enabled and enabled for stop
  spc_mode_e mode;       // effective stop mode
  logic      reg_active; // regulator stays active in stop
  modport req (output deep_sel, dbg_en, lvd_stop, input mode, reg_active);
  modport res (input deep_sel, dbg_en, lvd_stop, output mode, reg_active);
endinterface
`default_nettype wire

// File: hw/spc_mode_resolve.sv
// Purpose: resolves the effective stop mode and regulator need
// Assumes: answer is sampled by the caller as the stop instruction executes
// Notes:   pure decode, no state
`timescale 1ns/1ps
`default_nettype none
module spc_mode_resolve
  import spc_pkg::*;
(
  // configuration in, decision out
  spc_stop_if.res stop_if
);
  // overrides that forbid the deep mode
  wire deep_blocked = stop_if.dbg_en | stop_if.lvd_stop;
  // deep only on select with no override
  assign stop_if.mode = (stop_if.deep_sel && !deep_blocked)
                        ? SPC_MODE_DEEP : SPC_MODE_LIGHT;
  // regulator kept up by debug or detector
  assign stop_if.reg_active = deep_blocked;
endmodule
`default_nettype wire

// File: hw/spc_sync.sv
// Purpose: two-flop synchroniser for pins from outside the core clock
// Assumes: each bit is an independent level
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(
  parameter int unsigned W       = 1,
  parameter logic        RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q; // first stage
  logic [W-1:0] sync_q; // second stage

  // two stages, reset to a constant
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= {W{RST_VAL}};
      sync_q <= {W{RST_VAL}};
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule
`default_nettype wire

// File: hw/spc_power_ctrl.sv
// Purpose: stop-mode power controller: mode choice, clock gating, wake and reset
// Assumes: CPU strobes and debug commands are on CORE_CLK_I; wake pins are not
// Notes:   registers behind a plain address/strobe port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module spc_power_ctrl
  import spc_pkg::*;
#(
  parameter int unsigned NW = N_WAKE
) (
  // clock and reset
  input  wire logic          CORE_CLK_I,
  input  wire logic          RST_N_I,
  // register port
  input  wire logic [2:0]    ADDR_I,
  input  wire logic [7:0]    WDATA_I,
  input  wire logic          WE_I,
  input  wire logic          RE_I,
  output logic      [7:0]    RDATA_O,
  // cpu side
  input  wire logic          STOP_EXEC_I,
  output logic               ILLEGAL_RST_O,
  output logic               CPU_STBY_O,
  // debug host side
  input  wire logic          DBG_BGND_CMD_I,
  input  wire logic          DBG_GO_CMD_I,
  input  wire logic          DBG_MEMSTAT_I,
  output logic               DBG_MEMSTAT_ERR_O,
  output logic               DBG_MEM_GRANT_O,
  output logic               DBG_ALL_CMDS_O,
  output logic               BGND_ACTIVE_O,
  // wake pins: rti, lvd, adc, irq, kbi, sci
  input  wire logic [NW-1:0] WAKE_SRC_I,
  input  wire logic          EXT_RST_PIN_N_I,
  // power and clock controls
  output logic               DBG_CLK_EN_O,
  output logic               PERIPH_CLK_EN_O,
  output logic               REG_ACTIVE_O,
  output logic               CLKGEN_ON_O,
  output logic               CLKGEN_STBY_O,
  output logic               CLKGEN_OFF_O,
  output logic               OSC_RUN_O,
  output logic               ADC_STBY_O,
  output logic               KBI_WAKE_EN_O,
  output logic               KBI_OFF_O,
  output logic               PIN_LATCH_O,
  output logic               SYS_RST_N_O,
  output logic      [1:0]    STOP_MODE_O
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NW != N_WAKE)
  begin : g_bad_nw
    $error("wake source count must match the wake mask");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  spc_state_e state_q, state_d;   // controller state
  spc_mode_e  mode_q;             // mode latched at stop entry
  logic       reg_act_q;          // regulator need latched at entry
  logic       dss_q, low_volt_detect_enable_q;      // deep select, detector enable
  logic       lvse_q, allow_q;    // detector stop enable, stop allowed
  logic       dee_q, osc_q;       // debug entry, oscillator keep
  logic       converter_async_clock_q;            // converter async clock
  logic       flag_q, latch_q;    // power-down flag, pin latch
  logic [2:0] cnt_q;              // wake reset length count
  logic       err_q, grant_q;     // debug memory answers
  logic       ill_q;              // illegal opcode reset pulse
  logic [7:0] rdata_q;            // read data register
  logic [NW-1:0] wake_s;          // synchronised wake sources
  logic       pin_rst_n_s;        // synchronised reset pin
  spc_stop_if stop_if ();         // resolver link

  // ----------------------------------------------------------------
  // input synchronisers and mode resolver
  // ----------------------------------------------------------------
  spc_sync #(.W(NW), .RST_VAL(1'b0)) u_wake_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (WAKE_SRC_I),
    .q_o     (wake_s)
  );
  spc_sync #(.W(1), .RST_VAL(1'b1)) u_pin_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (EXT_RST_PIN_N_I),
    .q_o     (pin_rst_n_s)
  );
  assign stop_if.deep_sel = dss_q;
  assign stop_if.dbg_en   = dee_q;
  assign stop_if.lvd_stop = low_volt_detect_enable_q & lvse_q;
  spc_mode_resolve u_resolve (
    .stop_if (stop_if.res)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire st_run   = (state_q == ST_RUN);
  wire st_light = (state_q == ST_LIGHT);
  wire st_deep  = (state_q == ST_DEEP);
  wire st_wake  = (state_q == ST_WAKE);
  wire stopped  = st_light | st_deep;
  wire stop_go  = st_run & STOP_EXEC_I & allow_q;
  wire stop_bad = st_run & STOP_EXEC_I & ~allow_q;
  wire go_deep  = stop_go & (stop_if.mode == SPC_MODE_DEEP);
  // wake from light: any interrupt source
  wire light_irq  = |wake_s;
  // wake from deep: reset pin or selected sources
  wire deep_wake  = (|(wake_s & DEEP_WAKE_MASK)) | ~pin_rst_n_s;
  wire wake_done  = st_wake & (cnt_q == 3'(WAKE_RST_CYC - 1));
  // register resets: core reset or wake reset pulse
  wire cfg_rst    = ~RST_N_I | st_wake;
  wire wr_pm      = WE_I & (ADDR_I == OFS_PWR_MODE);
  wire ack_wr     = wr_pm & WDATA_I[PM_ACK_BIT];
  wire bgnd_go    = st_light & DBG_BGND_CMD_I & dee_q;
  // detector kept in light stop without debug: generator off
  wire cg_off_lvd = st_light & ~dee_q & stop_if.lvd_stop;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      // run: resolve the mode once at the stop instruction
      ST_RUN:
      begin
        if (stop_go)
          state_d = go_deep ? ST_DEEP : ST_LIGHT;
      end
      // light: reset pin resets, interrupts resume, debug may break in
      ST_LIGHT:
      begin
        if (!pin_rst_n_s)
          state_d = ST_WAKE;
        else if (bgnd_go)
          state_d = ST_BGND;
        else if (light_irq)
          state_d = ST_RUN;
      end
      // deep: any wake goes through a full system reset
      ST_DEEP:
      begin
        if (deep_wake)
          state_d = ST_WAKE;
      end
      // reset pulse of fixed length
      ST_WAKE:
      begin
        if (wake_done)
          state_d = ST_RUN;
      end
      // background until the host resumes the program
      ST_BGND:
      begin
        if (DBG_GO_CMD_I)
          state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  // state, mode and regulator decision registers
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_q   <= ST_RUN;
      mode_q    <= SPC_MODE_LIGHT;
      reg_act_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (stop_go)
      begin
        mode_q    <= stop_if.mode;
        reg_act_q <= stop_if.reg_active;
      end
    end
  end

  // wake reset length counter
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I || !st_wake)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_q + 3'h1;
  end

  // ----------------------------------------------------------------
  // configuration registers, cleared by the deep wake reset
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (cfg_rst)
    begin
      dss_q   <= CFG_RST_VAL;
      low_volt_detect_enable_q  <= CFG_RST_VAL;
      lvse_q  <= CFG_RST_VAL;
      allow_q <= CFG_RST_VAL;
      dee_q   <= CFG_RST_VAL;
      osc_q   <= CFG_RST_VAL;
      converter_async_clock_q <= CFG_RST_VAL;
    end
    else if (WE_I)
    begin
      // power mode control
      if (ADDR_I == OFS_PWR_MODE)
      begin
        dss_q  <= WDATA_I[PM_DSS_BIT];
        low_volt_detect_enable_q <= WDATA_I[PM_LOW_VOLT_DETECT_ENABLE_BIT];
        lvse_q <= WDATA_I[PM_LVSE_BIT];
      end
      // system option
      if (ADDR_I == OFS_SYS_OPT)
        allow_q <= WDATA_I[SO_STOP_BIT];
      // debug status and control
      if (ADDR_I == OFS_DBG_CTL)
        dee_q <= WDATA_I[DC_DEE_BIT];
      // clock and converter options
      if (ADDR_I == OFS_CLK_CFG)
      begin
        osc_q   <= WDATA_I[CC_OSC_BIT];
        converter_async_clock_q <= WDATA_I[CC_ADAC_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // retained flag and pin latch: survive the wake reset
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      flag_q  <= 1'b0;
      latch_q <= 1'b0;
    end
    else
    begin
      // flag set on deep wake wins over acknowledge
      if (st_deep && deep_wake)
        flag_q <= 1'b1;
      else if (ack_wr && !st_wake && !st_deep)
        flag_q <= 1'b0;
      // latch closes entering deep, opens on acknowledge
      if (go_deep)
        latch_q <= 1'b1;
      else if (ack_wr && !st_wake && !st_deep)
        latch_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read port and debug/cpu answers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      rdata_q <= 8'h00;
      err_q   <= 1'b0;
      grant_q <= 1'b0;
      ill_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= 8'h00;
      if (RE_I)
      begin
        unique case (ADDR_I)
          OFS_PWR_MODE:
          begin
            rdata_q[PM_DSS_BIT]  <= dss_q;
            rdata_q[PM_FLAG_BIT] <= flag_q;
            rdata_q[PM_LOW_VOLT_DETECT_ENABLE_BIT] <= low_volt_detect_enable_q;
            rdata_q[PM_LVSE_BIT] <= lvse_q;
          end
          OFS_SYS_OPT: rdata_q[SO_STOP_BIT] <= allow_q;
          OFS_DBG_CTL: rdata_q[DC_DEE_BIT]  <= dee_q;
          OFS_CLK_CFG:
          begin
            rdata_q[CC_OSC_BIT]  <= osc_q;
            rdata_q[CC_ADAC_BIT] <= converter_async_clock_q;
          end
          OFS_STATUS:
          begin
            rdata_q[2:0]          <= state_q;
            rdata_q[4:3]          <= mode_q;
            rdata_q[ST_LATCH_BIT] <= latch_q;
          end
          default: rdata_q <= 8'h00;
        endcase
      end
      // memory-status command: error in stop, access otherwise
      err_q   <= DBG_MEMSTAT_I & stopped;
      grant_q <= DBG_MEMSTAT_I & ~stopped;
      ill_q   <= stop_bad;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA_O           = rdata_q;
  assign DBG_MEMSTAT_ERR_O = err_q;
  assign DBG_MEM_GRANT_O   = grant_q;
  assign ILLEGAL_RST_O     = ill_q;
  assign BGND_ACTIVE_O     = (state_q == ST_BGND);
  assign DBG_ALL_CMDS_O    = (state_q == ST_BGND);
  assign CPU_STBY_O        = stopped;
  assign DBG_CLK_EN_O      = ~stopped | (st_light & dee_q);
  assign PERIPH_CLK_EN_O   = ~stopped & ~st_wake;
  assign REG_ACTIVE_O      = ~stopped | reg_act_q;
  assign CLKGEN_ON_O       = ~stopped | (st_light & dee_q);
  assign CLKGEN_STBY_O     = st_light & ~dee_q & ~stop_if.lvd_stop;
  assign CLKGEN_OFF_O      = st_deep | cg_off_lvd;
  assign OSC_RUN_O         = ~stopped | (st_light & (dee_q | osc_q) & ~cg_off_lvd);
  assign ADC_STBY_O        = st_deep | (st_light & ~converter_async_clock_q);
  assign KBI_WAKE_EN_O     = st_light;
  assign KBI_OFF_O         = st_deep;
  assign PIN_LATCH_O       = latch_q;
  assign SYS_RST_N_O       = ~st_wake;
  assign STOP_MODE_O       = stopped ? mode_q : 2'h3;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_deep_wake;
    st_deep && deep_wake;
  endsequence
  sequence s_wake_pulse;
    !SYS_RST_N_O [*4] ##1 (SYS_RST_N_O && flag_q && st_run);
  endsequence

  AST_DBG_CLK: assert property (stop_go && dee_q |=> st_light && DBG_CLK_EN_O)
    else $error("debug clock lost in stop with debug enabled");
  AST_REG_ACT: assert property (stop_go && (dee_q || (low_volt_detect_enable_q && lvse_q))
    |=> stopped && REG_ACTIVE_O)
    else $error("regulator not held active in stop");
  AST_NO_DEEP: assert property (stop_go && dss_q && (dee_q || (low_volt_detect_enable_q && lvse_q))
    |=> st_light && !PIN_LATCH_O)
    else $error("deep stop entered despite override");
  AST_MEMSTAT: assert property (stopped && DBG_MEMSTAT_I
    |=> DBG_MEMSTAT_ERR_O && !DBG_MEM_GRANT_O)
    else $error("memory access allowed in stop");
  AST_BGND: assert property (bgnd_go && pin_rst_n_s
    |=> BGND_ACTIVE_O && DBG_ALL_CMDS_O && !CPU_STBY_O)
    else $error("background command did not leave stop");
  AST_PCLK: assert property ($rose(stopped) |-> !PERIPH_CLK_EN_O)
    else $error("peripheral clocks run in stop");
  AST_ILLEGAL: assert property (stop_bad |=> ILLEGAL_RST_O && st_run)
    else $error("stop without permission not trapped");
  AST_DEEP_WAKE: assert property (s_deep_wake |=> s_wake_pulse)
    else $error("deep wake reset or flag wrong");
  AST_DEEP_SEL: assert property (stop_go && dss_q && !dee_q && !(low_volt_detect_enable_q && lvse_q)
    |=> st_deep && PIN_LATCH_O && CLKGEN_OFF_O)
    else $error("deep stop not selected");
endmodule
`default_nettype wire

// File: testbench/spc_far_model.sv
// Purpose: far-side model: wake pins, reset pin and serial debug host commands
// Assumes: all changes land just after a rising core clock edge
// Notes:   the bench calls the tasks; pins are levels, commands are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module spc_far_model (
  // clock
  input  wire logic       clk_i,
  // design answers that the far side reacts to
  input  wire logic       stby_i,
  input  wire logic       sys_rst_n_i,
  input  wire logic       bgnd_act_i,
  // wake and reset pins
  output logic      [5:0] wake_o,
  output logic            rst_pin_n_o,
  // debug host commands
  output logic            bgnd_o,
  output logic            go_o,
  output logic            memstat_o
);
  logic [5:0] req_q     = 6'h00; // wake sources raised by the tasks
  logic       pin_req_n = 1'b1;  // reset pin pulled low by the task
  int         cmd_k     = -1;    // pending host command, -1 for none
  // ----------------------------------------------------------------
  // pins and command lines, one clock after the request
  // ----------------------------------------------------------------
  // a serviced source drops once the core runs again; the supervisor
  // lets go of the pin once the design shows its reset; the host sends
  // go only in background and waits out a system reset
  always @(posedge clk_i)
  begin
    wake_o      <= req_q & {6{stby_i | ~sys_rst_n_i}};
    rst_pin_n_o <= pin_req_n | ~sys_rst_n_i;
    bgnd_o      <= (cmd_k == 0) & ~bgnd_act_i;
    go_o        <= (cmd_k == 1) & bgnd_act_i;
    memstat_o   <= (cmd_k == 2) & sys_rst_n_i;
  end
  // raise one wake source and hold it as a level
  task automatic raise(input int b);
    @(posedge clk_i);
    req_q[b] <= 1'b1;
  endtask
  // release every wake source
  task automatic drop_all();
    @(posedge clk_i);
    req_q <= 6'h00;
  endtask
  // drive the external reset pin
  task automatic pin(input logic v);
    @(posedge clk_i);
    pin_req_n <= v;
  endtask
  // one-cycle command: 0 background, 1 go, 2 memory access with status;
  // returns at the edge at which the design takes it
  task automatic cmd(input int k);
    @(posedge clk_i);
    cmd_k <= k;
    @(posedge clk_i);
    cmd_k <= -1;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: testbench/spc_power_ctrl_tb_top.sv
// Purpose: self-checking bench for the stop-mode power controller
// Assumes: far side is the spc_far_model instance
// Notes:   outputs are sampled 1 ns after the clock edge
`timescale 1ns/1ps
`default_nettype none
module spc_power_ctrl_tb_top;
  import spc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk, rst_n, we, re, stop_exec, pin_n, bgnd, go, mst;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [5:0] wake;
  logic [1:0] mode;
  logic       illegal, cpu_stby, mst_err, mst_grant, all_cmds, bgnd_act;
  logic       dbg_clk, per_clk, reg_act, cg_on, cg_stby, cg_off, osc;
  logic       adc_stby, kbi_wake, kbi_off, latch, sys_rst_n;
  int         n_fail, compares, i;
  int         cycles = 0;
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  spc_power_ctrl DUT (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WE_I(we), .RE_I(re), .RDATA_O(rdata), .STOP_EXEC_I(stop_exec),
    .ILLEGAL_RST_O(illegal), .CPU_STBY_O(cpu_stby), .DBG_BGND_CMD_I(bgnd),
    .DBG_GO_CMD_I(go), .DBG_MEMSTAT_I(mst), .DBG_MEMSTAT_ERR_O(mst_err),
    .DBG_MEM_GRANT_O(mst_grant), .DBG_ALL_CMDS_O(all_cmds),
    .BGND_ACTIVE_O(bgnd_act), .WAKE_SRC_I(wake), .EXT_RST_PIN_N_I(pin_n),
    .DBG_CLK_EN_O(dbg_clk), .PERIPH_CLK_EN_O(per_clk), .REG_ACTIVE_O(reg_act),
    .CLKGEN_ON_O(cg_on), .CLKGEN_STBY_O(cg_stby), .CLKGEN_OFF_O(cg_off),
    .OSC_RUN_O(osc), .ADC_STBY_O(adc_stby), .KBI_WAKE_EN_O(kbi_wake),
    .KBI_OFF_O(kbi_off), .PIN_LATCH_O(latch), .SYS_RST_N_O(sys_rst_n),
    .STOP_MODE_O(mode)
  );
  spc_far_model far (.clk_i(clk), .stby_i(cpu_stby), .sys_rst_n_i(sys_rst_n),
    .bgnd_act_i(bgnd_act), .wake_o(wake), .rst_pin_n_o(pin_n),
    .bgnd_o(bgnd), .go_o(go), .memstat_o(mst));
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // one-cycle read strobe, data compared in the following cycle only
  task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic stop_pulse();
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    #1;
  endtask
  // selects the level waited on: 0 standby, 1 system reset, 2 background
  function automatic logic pick(input int k);
    return (k == 0) ? cpu_stby : ((k == 1) ? sys_rst_n : bgnd_act);
  endfunction
  // bounded wait for a level, then compared
  task automatic wait_sig(input string what, input int k, input logic v);
    i = 0;
    while (pick(k) !== v && i < 12)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk1(what, v, pick(k));
  endtask
  task automatic complete_run();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {we, re, stop_exec} = 3'b000;
    addr = 3'h0;
    wdata = 8'h00;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values and an unmapped address
    rd("pwr_mode", OFS_PWR_MODE, 8'h00);
    rd("status", OFS_STATUS, 8'h00);
    rd("unmapped", 3'h7, 8'h00);
    // stop while not allowed
    stop_pulse();
    chk1("illegal_rst", 1'b1, illegal);
    chk1("no_stby", 1'b0, cpu_stby);
    // plain light stop, oscillator kept, converter on its own clock
    wr(OFS_SYS_OPT, 8'h01);
    wr(OFS_CLK_CFG, 8'h03);
    stop_pulse();
    chk("light_mode", 8'h00, {6'h00, mode});
    chk1("per_clk_off", 1'b0, per_clk);
    chk1("dbg_clk_off", 1'b0, dbg_clk);
    chk1("reg_stby", 1'b0, reg_act);
    chk1("cg_stby", 1'b1, cg_stby);
    chk1("osc_kept", 1'b1, osc);
    chk1("adc_running", 1'b0, adc_stby);
    chk1("kbi_wake", 1'b1, kbi_wake);
    chk1("no_latch", 1'b0, latch);
    far.cmd(2);
    #1;
    chk1("memstat_err", 1'b1, mst_err);
    far.raise(4);
    wait_sig("kbi_woke", 0, 1'b0);
    far.drop_all();
    rd("kept_opt", OFS_SYS_OPT, 8'h01);
    rd("kept_clk", OFS_CLK_CFG, 8'h03);
    // deep request with debug entry enabled
    wr(OFS_DBG_CTL, 8'h01);
    wr(OFS_PWR_MODE, 8'h01);
    stop_pulse();
    chk("dbg_light", 8'h00, {6'h00, mode});
    chk1("dbg_clk_on", 1'b1, dbg_clk);
    chk1("reg_full", 1'b1, reg_act);
    chk1("cg_active", 1'b1, cg_on);
    chk1("per_off_dbg", 1'b0, per_clk);
    far.cmd(0);
    wait_sig("bgnd_on", 2, 1'b1);
    chk1("all_cmds", 1'b1, all_cmds);
    far.cmd(2);
    #1;
    chk1("memstat_grant", 1'b1, mst_grant);
    far.cmd(1);
    wait_sig("bgnd_off", 2, 1'b0);
    wr(OFS_DBG_CTL, 8'h00);
    // deep request with low-voltage detection kept in stop
    wr(OFS_PWR_MODE, 8'h19);
    stop_pulse();
    chk("lvd_light", 8'h00, {6'h00, mode});
    chk1("lvd_reg", 1'b1, reg_act);
    chk1("lvd_cg_off", 1'b1, cg_off);
    chk1("lvd_no_stby", 1'b0, cg_stby);
    chk1("lvd_osc_off", 1'b0, osc);
    far.raise(0);
    wait_sig("timer_woke", 0, 1'b0);
    far.drop_all();
    // true deep stop, keypad must not wake it, irq pin does
    wr(OFS_PWR_MODE, 8'h01);
    wr(OFS_CLK_CFG, 8'h01);
    stop_pulse();
    chk("deep_mode", 8'h01, {6'h00, mode});
    chk1("latched", 1'b1, latch);
    chk1("cg_off", 1'b1, cg_off);
    chk1("osc_off", 1'b0, osc);
    chk1("adc_stby", 1'b1, adc_stby);
    chk1("kbi_off", 1'b1, kbi_off);
    chk1("reg_low", 1'b0, reg_act);
    far.raise(4);
    repeat (6) @(posedge clk);
    #1;
    chk1("kbi_no_wake", 1'b1, cpu_stby);
    far.drop_all();
    far.raise(3);
    wait_sig("wake_rst", 1, 1'b0);
    chk1("per_off_rst", 1'b0, per_clk);
    wait_sig("wake_rst_end", 1, 1'b1);
    chk("wake_len", WAKE_RST_CYC[7:0], i[7:0]);
    far.drop_all();
    rd("flag_set", OFS_PWR_MODE, 8'h04);
    rd("opt_reset", OFS_SYS_OPT, 8'h00);
    chk1("latch_held", 1'b1, latch);
    wr(OFS_PWR_MODE, 8'h02);
    rd("flag_clear", OFS_PWR_MODE, 8'h00);
    chk1("latch_open", 1'b0, latch);
    // light stop left through the reset pin sets no flag
    wr(OFS_SYS_OPT, 8'h01);
    stop_pulse();
    far.pin(1'b0);
    wait_sig("pin_rst", 1, 1'b0);
    far.pin(1'b1);
    wait_sig("pin_rst_end", 1, 1'b1);
    rd("no_flag", OFS_PWR_MODE, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
